/* verilog/bcw_loader.sv */
// Boot configuration word loader: source selection, fetch, lock flag, options
//
// Behaviour
// RL1: After reset, read the word from byte addresses 0x20 to 0x23 of the source.
// RL2: Source follows both select pins and lock flag; both low picks flash on the flash variant.
// RL3: High select pin at 1 fetches from special-function ROM, always.
// RL4: Flash variant, pins 0/1: flash if lock is 1, external port if 0.
// RL5: External fetch only after non-power-on reset with lock cleared before.
// RL6: Lock flag is 1 after power-up and then blocks external port access.
// RL7: Only internal software can clear the lock flag; external access cannot.
// RL8: Mask-ROM variant: lock does not lock; 0/0 internal ROM, 0/1 external.
// RL9: Fetched word is stored in the configuration register when leaving reset.
// RL10: Word 0x7F5F in bits 15:0 starts from internal 16-bit memory.
// RL11: Software programs option field then copies it into option registers.
// RL12: Flash/emulation: all options writable; mask ROM: clock/monitor fixed.
module bcw_loader
(
	// Clock and reset
	input  wire logic                       i_ref_clk,
	input  wire logic                       i_rst,
	input  wire logic                       i_power_on_rst,
	// Variant and pins
	input  wire logic                       i_flash_variant,
	input  wire logic                       i_boot_select_high,
	input  wire logic                       i_boot_select_low,
	// Byte fetch port towards the chosen memory
	output logic                            o_fetch_req,
	output logic [7:0]                      o_fetch_addr,
	output bcw_pkg::bcw_src_t               o_fetch_src,
	input  wire logic                       i_fetch_ack,
	input  wire logic [7:0]                 i_fetch_data,
	// Configuration result
	output logic [31:0]                     o_config_holding_register,
	output logic                            o_config_valid,
	output logic                            o_int16_boot,
	// Port lock
	input  wire logic                       i_sw_lock_clear,
	input  wire logic                       i_ext_lock_clear,
	output logic                            o_port_lock_flag,
	output logic                            o_ext_port_block,
	// Hardware options
	input  wire logic                       i_opt_wr,
	input  wire logic [bcw_pkg::BCW_OPT_W-1:0] i_opt_data,
	input  wire logic [bcw_pkg::BCW_OPT_W-1:0] i_opt_mask_value,
	output logic [bcw_pkg::BCW_OPT_W-1:0]  o_opt_reg
);
	import bcw_pkg::*;

	typedef struct packed
	{
		bcw_state_t  state;
		bcw_src_t    src;
		logic [7:0]  addr;
		logic [31:0] word;
		logic [31:0] cfg;
		logic        valid;
		logic        lock;
		logic        lock_seen;
		logic [BCW_OPT_W-1:0] opt;
	} bcw_reg_t;

	bcw_reg_t r;
	bcw_reg_t next_r;

	// Boot-select pins after two flops
	logic [1:0] sel_meta;
	logic [1:0] sel_sync;

	// ------------------------------------------------------------------
	// Boot-select synchroniser
	// ------------------------------------------------------------------
	// No reset on these flops: they keep tracking the pins while reset
	// is active, so the levels are settled when the fetch starts
	always_ff @(posedge i_ref_clk)
	begin
		sel_meta <= {i_boot_select_high, i_boot_select_low};
		sel_sync <= sel_meta;
	end

	// ------------------------------------------------------------------
	// Source decode
	// ------------------------------------------------------------------
	function automatic bcw_src_t pick_src(input logic hi, input logic lo,
		input logic flash, input logic lock, input logic ext_ok);
		bcw_src_t s;
		s = BCW_SRC_FLASH;
		case ({hi, lo})
			2'b00:
			begin
				if (flash)
					s = BCW_SRC_FLASH; // RL2
				else
					s = BCW_SRC_IROM; // RL8
			end
			2'b01:
			begin
				if (!flash)
					s = BCW_SRC_EXT; // RL8
				else if (!lock && ext_ok)
					s = BCW_SRC_EXT; // RL4 RL5
				else
					s = BCW_SRC_FLASH; // RL4
			end
			2'b10:
				s = BCW_SRC_SFROM; // RL3
			2'b11:
				s = BCW_SRC_SFROM; // RL3
			default:
				s = BCW_SRC_FLASH;
		endcase
		return s;
	endfunction

	// ------------------------------------------------------------------
	// Option merge
	// ------------------------------------------------------------------
	// Mask-ROM parts keep the mask-wired clock and monitor bits
	function automatic logic [BCW_OPT_W-1:0] merge_opt(input logic flash,
		input logic [BCW_OPT_W-1:0] data, input logic [BCW_OPT_W-1:0] wired);
		logic [BCW_OPT_W-1:0] m;
		m = data;
		if (!flash)
			m = (data & ~BCW_OPT_FIXED_MASK) | (wired & BCW_OPT_FIXED_MASK);
		return m;
	endfunction

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb
	begin
		next_r = r;
		// Lock holds across warm resets; only internal software clears it
		if (i_sw_lock_clear)
			next_r.lock = 1'b0; // RL7
		// History frozen by a warm reset: was the lock clear before it
		next_r.lock_seen = !next_r.lock; // RL5
		case (r.state)
			BCW_ST_RESET:
			begin
				next_r.src   = pick_src(sel_sync[1], sel_sync[0], i_flash_variant, r.lock,
					r.lock_seen); // RL2 RL5
				next_r.addr  = BCW_ADDR_FIRST; // RL1
				next_r.state = BCW_ST_REQ;
			end
			BCW_ST_REQ:
			begin
				if (i_fetch_ack)
				begin
					next_r.word = {i_fetch_data, r.word[31:8]}; // RL1
					if (r.addr == BCW_ADDR_LAST)
						next_r.state = BCW_ST_WAIT;
					else
						next_r.addr = r.addr + 8'h01;
				end
			end
			BCW_ST_WAIT:
			begin
				next_r.cfg   = r.word; // RL9
				next_r.valid = 1'b1;
				next_r.state = BCW_ST_RUN;
			end
			BCW_ST_RUN:
			begin
				if (i_opt_wr)
				begin
					next_r.opt = merge_opt(i_flash_variant, i_opt_data,
						i_opt_mask_value); // RL11 RL12
				end
			end
			default:
				next_r.state = BCW_ST_RESET;
		endcase
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	// Power-on reset clears everything and sets the lock; a warm reset
	// restarts the fetch but leaves the lock and its history untouched
	always_ff @(posedge i_ref_clk or posedge i_rst or posedge i_power_on_rst)
	begin
		if (i_power_on_rst)
		begin
			// Sequencer
			r.state     <= BCW_ST_RESET;
			r.src       <= BCW_SRC_FLASH;
			r.addr      <= BCW_ADDR_FIRST;
			r.word      <= BCW_CFG_RESET;

			// Result
			r.cfg       <= BCW_CFG_RESET;
			r.valid     <= 1'b0;
			r.opt       <= BCW_OPT_RESET;

			// Lock
			r.lock      <= BCW_LOCK_PWRUP; // RL6
			r.lock_seen <= 1'b0; // RL5
		end
		else if (i_rst)
		begin
			// Sequencer
			r.state     <= BCW_ST_RESET;
			r.src       <= BCW_SRC_FLASH;
			r.addr      <= BCW_ADDR_FIRST;
			r.word      <= BCW_CFG_RESET;

			// Result
			r.cfg       <= BCW_CFG_RESET;
			r.valid     <= 1'b0;
			r.opt       <= BCW_OPT_RESET;
		end
		else
		begin
			// Sequencer
			r.state     <= next_r.state;
			r.src       <= next_r.src;
			r.addr      <= next_r.addr;
			r.word      <= next_r.word;

			// Result
			r.cfg       <= next_r.cfg;
			r.valid     <= next_r.valid;
			r.opt       <= next_r.opt;

			// Lock
			r.lock      <= next_r.lock; // RL7
			r.lock_seen <= next_r.lock_seen; // RL5
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign o_fetch_req               = (r.state == BCW_ST_REQ);
	assign o_fetch_addr              = r.addr;
	assign o_fetch_src               = r.src;
	assign o_config_holding_register = r.cfg;
	assign o_config_valid            = r.valid;
	assign o_int16_boot              = r.valid && (r.cfg[15:0] == BCW_INT16_WORD); // RL10
	assign o_port_lock_flag          = r.lock;
	assign o_ext_port_block          = r.lock && i_flash_variant; // RL6 RL8
	assign o_opt_reg                 = r.opt;

endmodule

/* include/bcw_pkg.sv */
// Constants and types for the boot configuration word loader
package bcw_pkg;

	// ------------------------------------------------------------------
	// Fetch addresses
	// ------------------------------------------------------------------
	localparam logic [7:0] BCW_ADDR_FIRST = 8'h20;
	localparam logic [7:0] BCW_ADDR_LAST  = 8'h23;

	// ------------------------------------------------------------------
	// Reset values and the internal 16-bit boot word
	// ------------------------------------------------------------------
	localparam logic [31:0] BCW_CFG_RESET  = 32'h0000_0000;
	localparam logic        BCW_LOCK_PWRUP = 1'h1;
	localparam logic [15:0] BCW_INT16_WORD = 16'h7f5f;

	// ------------------------------------------------------------------
	// Option register width, reset value and fixed-bit mask
	// ------------------------------------------------------------------
	localparam int          BCW_OPT_W     = 32;
	localparam logic [31:0] BCW_OPT_RESET = 32'h0000_0000;
	localparam logic [31:0] BCW_OPT_FIXED_MASK = 32'h0000_00ff;

	// ------------------------------------------------------------------
	// Fetch sources and sequencer states
	// ------------------------------------------------------------------
	typedef enum logic [1:0]
	{
		BCW_SRC_FLASH = 2'b00,
		BCW_SRC_SFROM = 2'b01,
		BCW_SRC_EXT   = 2'b10,
		BCW_SRC_IROM  = 2'b11
	} bcw_src_t;

	typedef enum logic [1:0]
	{
		BCW_ST_RESET = 2'b00,
		BCW_ST_REQ   = 2'b01,
		BCW_ST_WAIT  = 2'b10,
		BCW_ST_RUN   = 2'b11
	} bcw_state_t;

endpackage

/* verif/bcw_loader_asserts.sv */
// Checker on the boot word loader ports
module bcw_loader_asserts
(
	// Watched ports
	input wire logic		i_ref_clk,
	input wire logic		i_rst,
	input wire logic		i_flash_variant,
	input wire logic		i_fetch_ack,
	input wire logic		o_fetch_req,
	input wire logic [7:0]		o_fetch_addr,
	input wire bcw_pkg::bcw_src_t	o_fetch_src,
	input wire logic [31:0]		o_config_holding_register,
	input wire logic		o_config_valid,
	input wire logic		o_port_lock_flag,
	input wire logic		o_ext_port_block
);
	import bcw_pkg::*;
	default clocking @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);
	AST_ADDR: assert property (o_fetch_req |-> o_fetch_addr inside {[8'h20:8'h23]})
		else $error("fetch address outside the word");
	AST_STEP: assert property (o_fetch_req && i_fetch_ack && o_fetch_addr != 8'h23
		|=> o_fetch_addr == $past(o_fetch_addr) + 8'h01) else $error("address did not step");
	AST_DONE: assert property (o_fetch_req && i_fetch_ack && o_fetch_addr == 8'h23
		|=> !o_fetch_req ##1 o_config_valid) else $error("word not stored");
	AST_HOLD: assert property (o_config_valid |=> o_config_valid
		&& $stable(o_config_holding_register)) else $error("word not held");
	AST_SRC: assert property (o_fetch_req
		|-> o_fetch_src != (i_flash_variant ? BCW_SRC_IROM : BCW_SRC_FLASH)) else $error("bad source");
	AST_EXT: assert property (o_fetch_req && i_flash_variant && o_fetch_src == BCW_SRC_EXT
		|-> !o_port_lock_flag) else $error("locked port fetched");
	AST_BLOCK: assert property (o_ext_port_block == (o_port_lock_flag && i_flash_variant))
		else $error("block flag wrong");
	AST_LOCK: assert property (!o_port_lock_flag |=> !o_port_lock_flag)
		else $error("lock set again");
endmodule
bind bcw_loader bcw_loader_asserts u_chk (.*);

/* verif/bcw_mem_model.sv */
// Byte memory behind the fetch port
module bcw_mem_model
(
	// Fetch port
	input wire logic		i_ref_clk,
	input wire logic		i_slow,
	input wire logic		i_req,
	input wire logic [7:0]		i_addr,
	input wire bcw_pkg::bcw_src_t	i_src,
	output logic			o_ack,
	output logic [7:0]		o_data
);
	import bcw_pkg::*;
	logic [31:0]	word;
	assign word = (i_src == BCW_SRC_FLASH) ? 32'h1234_7f5f : {4{6'h15, i_src}};
	assign o_data = o_ack ? word[8 * i_addr[1:0] +: 8] : ~word[7:0];
	initial o_ack = 1'h0;
	// Slow mode answers every other cycle
	always @(posedge i_ref_clk)
		o_ack <= i_req && (!i_slow || !o_ack);
endmodule

/* verif/bcw_loader_tb.sv */
// Self-checking bench for the boot word loader
module bcw_loader_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import bcw_pkg::*;
	logic clk = 1'h0, rst = 1'h1, por = 1'h1, fl = 1'h1, hi = 1'h0, lo = 1'h0;
	logic swc = 1'h0, exc = 1'h0, wr = 1'h0, slow = 1'h0, ack, req, ok, i16, lock, blk;
	logic [7:0] ad, dt;
	logic [31:0] cfg, opt, od = 32'h0, om = 32'h0;
	bcw_src_t src;
	int err_count = 0, checks = 0, cyc = 0;
	always #5 clk = ~clk;
	always @(posedge clk)
		if (++cyc == 2000)
		begin
			err_count++;
			final_report();
		end
	bcw_loader DUT (.i_ref_clk(clk), .i_rst(rst), .i_power_on_rst(por), .i_flash_variant(fl),
		.i_boot_select_high(hi), .i_boot_select_low(lo), .o_fetch_req(req), .o_fetch_addr(ad),
		.o_fetch_src(src), .i_fetch_ack(ack), .i_fetch_data(dt), .o_config_valid(ok),
		.o_config_holding_register(cfg), .o_int16_boot(i16), .i_sw_lock_clear(swc),
		.i_ext_lock_clear(exc), .o_port_lock_flag(lock), .o_ext_port_block(blk),
		.i_opt_wr(wr), .i_opt_data(od), .i_opt_mask_value(om), .o_opt_reg(opt));
	bcw_mem_model u_mem (.i_ref_clk(clk), .i_slow(slow), .i_req(req), .i_addr(ad),
		.i_src(src), .o_ack(ack), .o_data(dt));
	task automatic chk(input string n, input logic [31:0] e, g);
		checks++;
		err_count += int'(g !== e);
		if (g !== e)
			$display("[ERR] %s expected %h seen %h", n, e, g);
	endtask
	// Bits of v: power-on, flash variant, high pin, low pin, expected lock
	task automatic boot(input logic [4:0] v, input bcw_src_t s);
		@(negedge clk);
		{rst, por, fl, hi, lo} = {1'h1, v[4:1]};
		repeat (10) @(negedge clk);
		{rst, por} = 2'h0;
		for (int i = 0; i < 40 && ok !== 1'h1; i++)
			@(negedge clk);
		chk("source", s, src);
		chk("word", s == BCW_SRC_FLASH ? 32'h1234_7f5f : {4{6'h15, s}}, cfg);
		chk("int16", s == BCW_SRC_FLASH, i16);
		chk("lock", v[0], lock);
		chk("block", v[0] & v[3], blk);
	endtask
	// Bits of c: external clear, software clear, option copy
	task automatic act(input logic [2:0] c, input logic [31:0] d, e, input logic k);
		@(negedge clk);
		{exc, swc, wr, od, om} = {c, d, ~d};
		@(negedge clk);
		{exc, swc, wr} = 3'h0;
		chk("options", e, opt);
		chk("lock", k, lock);
	endtask
	task automatic final_report();
		if (err_count == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		boot(5'h19, BCW_SRC_FLASH);
		slow = 1'h1;
		boot(5'h0b, BCW_SRC_FLASH);
		act(3'h4, 32'h0, 32'h0, 1'h1);
		act(3'h2, 32'h0, 32'h0, 1'h0);
		boot(5'h0a, BCW_SRC_EXT);
		slow = 1'h0;
		boot(5'h0e, BCW_SRC_SFROM);
		boot(5'h08, BCW_SRC_FLASH);
		act(3'h1, 32'hc3a5_5a3c, 32'hc3a5_5a3c, 1'h0);
		boot(5'h1b, BCW_SRC_FLASH);
		boot(5'h11, BCW_SRC_IROM);
		boot(5'h03, BCW_SRC_EXT);
		boot(5'h05, BCW_SRC_SFROM);
		act(3'h1, 32'hc3a5_5a3c, 32'hc3a5_5ac3, 1'h1);
		final_report();
	end
endmodule
